// ---- gpib_far_model.sv ----
// Controller and listener model that faces the talker block's bus side.
module gpib_far_model (
  input logic clk_sys,
  input logic rst,
  input gpib_talker_pkg::gpib_out_s bus_o,
  input logic atn_set,
  input logic cmd_go,
  input gpib_talker_pkg::cmd_e cmd_code,
  input logic rfd_en,
  input logic slow,
  output gpib_talker_pkg::gpib_in_s bus_i,
  output logic [7:0] nbytes,
  output logic [7:0] last_byte,
  output logic last_eoi
);
  logic [1:0] dly;

  // Commands go out under ATN; listeners take a byte, stalling when slow.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_i <= '0;
      nbytes <= 8'h00;
      last_byte <= 8'h00;
      last_eoi <= 1'b0;
      dly <= 2'h0;
    end else begin
      bus_i.atn <= atn_set;
      bus_i.cmd_stb <= cmd_go;
      bus_i.cmd <= cmd_code;
      bus_i.rfd <= rfd_en && !bus_o.dav_oe && !bus_i.dac;
      if (!bus_o.dav_oe) begin
        bus_i.dac <= 1'b0;
        dly <= slow ? 2'h3 : 2'h0;
      end else if (dly != 2'h0) begin
        dly <= dly - 2'h1;
      end else if (!bus_i.dac) begin
        bus_i.dac <= 1'b1;
        nbytes <= nbytes + 8'h01;
        last_byte <= bus_o.dio;
        last_eoi <= bus_o.eoi_oe;
      end
    end
  end
endmodule

// ---- gpib_talker_end_serial_poll.sv ----
// Talker end-of-string, byte-out and serial poll logic with APB registers.
module gpib_talker_end_serial_poll (
  input logic clk_sys,
  input logic rst,
  input gpib_talker_pkg::apb_req_s apb_i,
  output gpib_talker_pkg::apb_rsp_s apb_o,
  input gpib_talker_pkg::gpib_in_s bus_i,
  output gpib_talker_pkg::gpib_out_s bus_o
);

  gpib_talker_pkg::state_s s_ff;
  gpib_talker_pkg::state_s nxt_s;
  logic wr;
  logic rd;
  logic hit;
  logic [7:0] adr;
  logic [31:0] wd;

  // Interrupt status byte built from the current state only.
  function automatic logic [7:0] int_stat(
    input gpib_talker_pkg::state_s s
  );
    logic [7:0] v;
    v = 8'h00;
    v[gpib_talker_pkg::INT_CMD] = (s.st == gpib_talker_pkg::T_SPAS);
    v[gpib_talker_pkg::INT_BO] = s.bo;
    v[gpib_talker_pkg::INT_IRQ] = s.irq;
    return v;
  endfunction

  // Status bits that can raise an interrupt, gated by the mask.
  function automatic logic masked_any(
    input gpib_talker_pkg::state_s s
  );
    logic [7:0] v;
    v = int_stat(s);
    v[gpib_talker_pkg::INT_IRQ] = 1'b0;
    return |(v & s.mask);
  endfunction

  // Read data for one register address.
  function automatic logic [7:0] rd_mux(
    input gpib_talker_pkg::state_s s,
    input logic [7:0] a
  );
    logic [7:0] v;
    v = 8'h00;
    case (a)
      gpib_talker_pkg::ADR_INT: begin
        v = int_stat(s);
      end
      gpib_talker_pkg::ADR_CMDST: begin
        v[gpib_talker_pkg::CST_SPAS] = (s.st == gpib_talker_pkg::T_SPAS);
      end
      gpib_talker_pkg::ADR_ADRST: begin
        v[gpib_talker_pkg::AST_TACS] = (s.st == gpib_talker_pkg::T_ACT);
        v[gpib_talker_pkg::AST_TADS] = (s.st == gpib_talker_pkg::T_ADDR);
      end
      gpib_talker_pkg::ADR_AUX: begin
        v[gpib_talker_pkg::AUX_FEOI] = s.feoi;
        v[gpib_talker_pkg::AUX_DACD] = s.dacd;
      end
      gpib_talker_pkg::ADR_SPOLL: begin
        v = s.sp;
        v[gpib_talker_pkg::SP_RSV] = s.srq;
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction

  // APB access decode; every access completes with no wait state.
  assign adr = apb_i.paddr;
  assign wd = apb_i.pwdata;
  assign wr = apb_i.psel && apb_i.penable && apb_i.pwrite;
  assign rd = apb_i.psel && apb_i.penable && !apb_i.pwrite;
  assign hit = (adr == gpib_talker_pkg::ADR_INT) ||
               (adr == gpib_talker_pkg::ADR_CMDST) ||
               (adr == gpib_talker_pkg::ADR_ADRST) ||
               (adr == gpib_talker_pkg::ADR_AUX) ||
               (adr == gpib_talker_pkg::ADR_SPOLL) ||
               (adr == gpib_talker_pkg::ADR_TOUT);

  // Next-state logic. Later assignments win, so sets follow clears.
  always_comb begin
    nxt_s = s_ff;
    nxt_s.feoi = 1'b0;
    // Talker state follows ATN; the poll state is entered on release.
    case (s_ff.st)
      gpib_talker_pkg::T_ACT, gpib_talker_pkg::T_SPAS: begin
        if (bus_i.atn) begin
          nxt_s.st = gpib_talker_pkg::T_ADDR;
        end
      end
      gpib_talker_pkg::T_ADDR: begin
        if (!bus_i.atn && s_ff.spe) begin
          nxt_s.st = gpib_talker_pkg::T_SPAS;
          nxt_s.srq = 1'b0;
          nxt_s.spas_nba = 1'b1;
          nxt_s.rsv_lock = 1'b1;
        end else if (!bus_i.atn) begin
          nxt_s.st = gpib_talker_pkg::T_ACT;
        end
      end
      default: begin
        nxt_s.st = s_ff.st;
      end
    endcase
    // Source handshake for data bytes and the poll status byte.
    case (s_ff.sh)
      gpib_talker_pkg::S_IDLE: begin
        if (s_ff.st == gpib_talker_pkg::T_ACT && s_ff.nba) begin
          nxt_s.dio = s_ff.tout;
          nxt_s.sh = gpib_talker_pkg::S_WAIT;
        end else if (s_ff.st == gpib_talker_pkg::T_SPAS &&
                     s_ff.spas_nba) begin
          nxt_s.dio = s_ff.sp;
          nxt_s.sh = gpib_talker_pkg::S_WAIT;
        end
      end
      gpib_talker_pkg::S_WAIT: begin
        if (bus_i.atn) begin
          nxt_s.sh = gpib_talker_pkg::S_IDLE;
        end else if (bus_i.rfd) begin
          nxt_s.sh = gpib_talker_pkg::S_DAV;
        end
      end
      gpib_talker_pkg::S_DAV: begin
        if (bus_i.atn) begin
          nxt_s.sh = gpib_talker_pkg::S_IDLE;
        end else if (bus_i.dac) begin
          nxt_s.sh = gpib_talker_pkg::S_IDLE;
          if (s_ff.st == gpib_talker_pkg::T_SPAS) begin
            nxt_s.rsv_lock = 1'b0;
            if (!s_ff.nba) begin
              nxt_s.spas_nba = 1'b0;
            end
          end else begin
            nxt_s.nba = 1'b0;
            nxt_s.end_pend = 1'b0;
          end
        end
      end
      default: begin
        nxt_s.sh = gpib_talker_pkg::S_IDLE;
      end
    endcase
    // Register writes.
    if (wr) begin
      case (adr)
        gpib_talker_pkg::ADR_INT: begin
          nxt_s.mask = wd[7:0];
        end
        gpib_talker_pkg::ADR_AUX: begin
          nxt_s.dacd = wd[gpib_talker_pkg::AUX_DACD];
          if (wd[gpib_talker_pkg::AUX_DACR]) begin
            nxt_s.cmd_hold = 1'b0;
          end
          if (wd[gpib_talker_pkg::AUX_FEOI]) begin
            nxt_s.feoi = 1'b1;
            nxt_s.end_pend = 1'b1;
          end
        end
        gpib_talker_pkg::ADR_SPOLL: begin
          nxt_s.sp = wd[7:0];
          if (s_ff.rsv_lock) begin
            nxt_s.sp[gpib_talker_pkg::SP_RSV] =
              s_ff.sp[gpib_talker_pkg::SP_RSV];
          end
          if (wd[gpib_talker_pkg::SP_RSV] &&
              !s_ff.sp[gpib_talker_pkg::SP_RSV]) begin
            nxt_s.srq = 1'b1;
          end
        end
        gpib_talker_pkg::ADR_TOUT: begin
          nxt_s.tout = wd[7:0];
          nxt_s.nba = 1'b1;
        end
        default: begin
          nxt_s.nba = nxt_s.nba;
        end
      endcase
    end
    // Commands received while ATN is asserted.
    if (bus_i.cmd_stb) begin
      if (s_ff.dacd) begin
        nxt_s.cmd_hold = 1'b1;
      end
      case (bus_i.cmd)
        gpib_talker_pkg::C_MTA: begin
          nxt_s.st = gpib_talker_pkg::T_ADDR;
        end
        gpib_talker_pkg::C_MLA, gpib_talker_pkg::C_OTA,
        gpib_talker_pkg::C_UNT: begin
          nxt_s.st = gpib_talker_pkg::T_IDLE;
        end
        gpib_talker_pkg::C_SPE: begin
          nxt_s.spe = 1'b1;
        end
        gpib_talker_pkg::C_SPD: begin
          nxt_s.spe = 1'b0;
        end
        default: begin
          nxt_s.spe = nxt_s.spe;
        end
      endcase
    end
    // Byte-out is the empty output register while in TACS.
    nxt_s.bo = (nxt_s.st == gpib_talker_pkg::T_ACT) && !nxt_s.nba;
    // Interrupt: read releases, a rising masked level sets.
    if (rd && adr == gpib_talker_pkg::ADR_INT) begin
      nxt_s.irq = 1'b0;
    end
    nxt_s.lvl = masked_any(s_ff);
    if (nxt_s.lvl && !s_ff.lvl) begin
      nxt_s.irq = 1'b1;
    end
    // Read data is captured in the setup cycle.
    if (apb_i.psel && !apb_i.penable) begin
      nxt_s.prdata = {24'h000000, rd_mux(s_ff, adr)};
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_ff <= '{st: gpib_talker_pkg::T_IDLE, sh: gpib_talker_pkg::S_IDLE,
                mask: gpib_talker_pkg::MASK_RST,
                tout: gpib_talker_pkg::BYTE_RST,
                sp: gpib_talker_pkg::BYTE_RST,
                dio: gpib_talker_pkg::BYTE_RST,
                prdata: 32'h00000000, default: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Port outputs.
  assign apb_o.prdata = s_ff.prdata;
  assign apb_o.pready = 1'b1;
  assign apb_o.pslverr = apb_i.psel && apb_i.penable && !hit;
  assign bus_o.dio = s_ff.dio;
  assign bus_o.dio_oe = (s_ff.sh != gpib_talker_pkg::S_IDLE);
  assign bus_o.od_val = 1'b0;
  assign bus_o.dav_oe = (s_ff.sh == gpib_talker_pkg::S_DAV);
  assign bus_o.eoi_oe = s_ff.end_pend &&
                        (s_ff.st == gpib_talker_pkg::T_ACT);
  assign bus_o.srq_oe = s_ff.srq;
  assign bus_o.cmd_hold = s_ff.cmd_hold;
  assign bus_o.irq_oe = s_ff.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // The force-end bit reads back set for exactly one cycle.
  a_feoi_self_clr: assert property (
    $rose(s_ff.feoi) |=> !s_ff.feoi && s_ff.end_pend)
    else $error("force-end bit did not clear after one cycle");

  // A pending end survives outside TACS.
  a_end_held: assert property (
    s_ff.end_pend && s_ff.st != gpib_talker_pkg::T_ACT |=> s_ff.end_pend)
    else $error("end request lost outside TACS");

  // EOI drops once the last byte is accepted.
  a_eoi_release: assert property (
    bus_o.eoi_oe && bus_o.dav_oe && bus_i.dac && !bus_i.atn &&
    !(wr && adr == gpib_talker_pkg::ADR_AUX) |=> !bus_o.eoi_oe)
    else $error("EOI held after byte acceptance");

  // ATN clears byte-out on the next edge and holds it clear.
  a_bo_atn_clr: assert property (
    bus_i.atn [*2] |=> !s_ff.bo && s_ff.st != gpib_talker_pkg::T_ACT)
    else $error("byte-out set or TACS kept under ATN");

  // Holdoff catches every command.
  a_cmd_hold: assert property (
    bus_i.cmd_stb && s_ff.dacd |=> bus_o.cmd_hold)
    else $error("command not held with holdoff set");

  // Writing hex 10 to aux releases the handshake and holdoff.
  a_rel_hex10: assert property (
    wr && adr == gpib_talker_pkg::ADR_AUX && wd[7:0] == 8'h10 &&
    !bus_i.cmd_stb |=> !bus_o.cmd_hold && !s_ff.dacd)
    else $error("hex 10 write did not release the held command");

  // Poll entry releases SRQ and shows poll status.
  a_spas_entry: assert property (
    $rose(s_ff.st == gpib_talker_pkg::T_SPAS) |->
    !bus_o.srq_oe && rd_mux(s_ff, gpib_talker_pkg::ADR_CMDST) == 8'h04)
    else $error("poll entry effects missing");

  // Status byte sent once when no talker byte waits.
  a_poll_once: assert property (
    s_ff.st == gpib_talker_pkg::T_SPAS && bus_o.dav_oe && bus_i.dac &&
    !bus_i.atn && !s_ff.nba |=> ##1 !bus_o.dio_oe)
    else $error("status byte repeated with no pending data");

  // Read of interrupt status releases IRQ unless a new edge arrives.
  a_irq_release: assert property (
    rd && adr == gpib_talker_pkg::ADR_INT && !(masked_any(s_ff) &&
    !s_ff.lvl) |=> !bus_o.irq_oe)
    else $error("IRQ not released by status read");

  // IRQ only rises from a masked status bit.
  a_irq_masked: assert property (
    $rose(bus_o.irq_oe) |-> $past(masked_any(s_ff)))
    else $error("IRQ raised without an enabled status bit");

  // Byte-out comes back once the listeners take a talker byte.
  a_bo_accept: assert property (
    s_ff.st == gpib_talker_pkg::T_ACT && bus_o.dav_oe && bus_i.dac &&
    !bus_i.atn && !bus_i.cmd_stb &&
    !(wr && adr == gpib_talker_pkg::ADR_TOUT) |=> s_ff.bo)
    else $error("byte-out not set after byte acceptance");

  // Untalking commands idle the talker and keep byte-out clear.
  a_untalk_idle: assert property (
    bus_i.cmd_stb && bus_i.cmd inside {gpib_talker_pkg::C_MLA,
    gpib_talker_pkg::C_OTA, gpib_talker_pkg::C_UNT} |=>
    s_ff.st == gpib_talker_pkg::T_IDLE && !s_ff.bo)
    else $error("talker not idled by untalking command");

  // A new service request write pulls SRQ on the next edge.
  a_srq_drive: assert property (
    wr && adr == gpib_talker_pkg::ADR_SPOLL &&
    wd[gpib_talker_pkg::SP_RSV] && !s_ff.sp[gpib_talker_pkg::SP_RSV]
    |=> bus_o.srq_oe)
    else $error("SRQ not driven after service request write");

  // Poll status drops as soon as ATN takes the device out of the poll.
  a_spas_leave: assert property (
    s_ff.st == gpib_talker_pkg::T_SPAS && bus_i.atn |=>
    rd_mux(s_ff, gpib_talker_pkg::ADR_CMDST) == 8'h00)
    else $error("poll status kept after leaving the poll");

  // The service-request bit cannot change while the poll byte is untaken.
  a_rsv_locked: assert property (
    wr && adr == gpib_talker_pkg::ADR_SPOLL && s_ff.rsv_lock |=>
    s_ff.sp[gpib_talker_pkg::SP_RSV] ==
    $past(s_ff.sp[gpib_talker_pkg::SP_RSV]))
    else $error("service request cleared before the byte was taken");

  // DAV only follows a ready-for-data seen on the previous edge.
  a_dav_after_rfd: assert property (
    $rose(bus_o.dav_oe) |-> $past(bus_i.rfd))
    else $error("DAV asserted without RFD");

endmodule

// ---- gpib_talker_pkg.sv ----
// Constants, types and structs for the instrument-bus talker block.
// What this block does
// - Force-end is aux bit 5; a pending end in TACS drives EOI.
// - The force-end bit clears itself one clock after the host sets it.
// - EOI stays asserted until the next data byte is accepted.
// - An end request made outside TACS waits; only reset cancels it.
// - Byte-out sets when the byte is accepted while in TACS.
// - ATN asserted leaves TACS and clears byte-out while ATN holds.
// - MLA, OTA or UNT puts the talker idle; byte-out stays clear.
// - MTA clears byte-out under ATN and, unless SPE was received, sets it again after ATN.
// - With holdoff set, every received command handshake is held.
// - Writing hex 10 to aux clears holdoff and releases the held command.
// - Service request is poll bit 6 and drives SRQ; other bits are status.
// - With SPE received, the addressed talker enters the serial poll state on ATN release.
// - Poll entry sets poll/command status, releases SRQ, puts byte out.
// - Poll status bits follow the state; late read shows hex 10.
// - Poll-active status clears when the controller ends the poll.
// - Service request cannot be cleared before the status byte is taken.
// - Status byte goes out with DAV once the controller shows RFD.
// - With no talker byte pending the status byte is sent once.
// - With a talker byte pending the status byte repeats on each RFD.
// - After a poll the host must clear service request before a new one.
// - Reading the interrupt status register releases IRQ.
// - A status bit raises IRQ only when its mask bit is set.
package gpib_talker_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADR_INT = 8'h00;
  localparam logic [7:0] ADR_CMDST = 8'h04;
  localparam logic [7:0] ADR_ADRST = 8'h08;
  localparam logic [7:0] ADR_AUX = 8'h0c;
  localparam logic [7:0] ADR_SPOLL = 8'h10;
  localparam logic [7:0] ADR_TOUT = 8'h14;

  // Field positions.
  localparam int AUX_FEOI = 5;
  localparam int AUX_DACR = 4;
  localparam int AUX_DACD = 2;
  localparam int SP_RSV = 6;
  localparam int INT_IRQ = 4;
  localparam int INT_CMD = 2;
  localparam int INT_BO = 1;
  localparam int CST_SPAS = 2;
  localparam int AST_TACS = 3;
  localparam int AST_TADS = 1;

  // Reset values.
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [1:0] {T_IDLE, T_ADDR, T_ACT, T_SPAS} talk_e;
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_DAV} src_e;
  typedef enum logic [2:0] {
    C_OTHER, C_MTA, C_MLA, C_OTA, C_UNT, C_SPE, C_SPD
  } cmd_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic atn;
    logic rfd;
    logic dac;
    logic cmd_stb;
    cmd_e cmd;
  } gpib_in_s;

  typedef struct packed {
    logic [7:0] dio;
    logic dio_oe;
    logic od_val;
    logic dav_oe;
    logic eoi_oe;
    logic srq_oe;
    logic cmd_hold;
    logic irq_oe;
  } gpib_out_s;

  typedef struct packed {
    talk_e st;
    src_e sh;
    logic feoi;
    logic end_pend;
    logic dacd;
    logic cmd_hold;
    logic spe;
    logic nba;
    logic [7:0] tout;
    logic [7:0] sp;
    logic srq;
    logic spas_nba;
    logic rsv_lock;
    logic bo;
    logic [7:0] mask;
    logic irq;
    logic lvl;
    logic [7:0] dio;
    logic [31:0] prdata;
  } state_s;

endpackage

// ---- tb.sv ----
// Self-checking testbench for the talker end and serial poll block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, atn_set, cmd_go, rfd_en, slow, e;
  gpib_talker_pkg::cmd_e cmd_code;
  gpib_talker_pkg::cmd_e unt[3];
  gpib_talker_pkg::apb_req_s apb_i;
  gpib_talker_pkg::apb_rsp_s apb_o;
  gpib_talker_pkg::gpib_in_s bus_i;
  gpib_talker_pkg::gpib_out_s bus_o;
  logic [7:0] nbytes, last_byte, nb0;
  logic [31:0] q;
  logic last_eoi;
  int fails, checks;

  gpib_talker_end_serial_poll i_dut (
    .clk_sys(clk_sys), .rst(rst), .apb_i(apb_i), .apb_o(apb_o),
    .bus_i(bus_i), .bus_o(bus_o));
  gpib_far_model i_far (
    .clk_sys(clk_sys), .rst(rst), .bus_o(bus_o), .atn_set(atn_set),
    .cmd_go(cmd_go), .cmd_code(cmd_code), .rfd_en(rfd_en), .slow(slow),
    .bus_i(bus_i), .nbytes(nbytes), .last_byte(last_byte),
    .last_eoi(last_eoi));

  // Free-running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Prints the verdict and stops.
  task automatic complete_run();
    if (fails == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compares a value read back or captured by the far side.
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  // Compares one bus pin.
  task automatic chk_pin(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t pin %b expected %b", $time, got, exp);
    end
  endtask

  // Counts a wait that ran out and ends the run.
  task automatic give_up();
    fails++;
    $display("ERROR %0t wait timed out", $time);
    complete_run();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One APB transfer: setup, access until ready, then one idle cycle.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    apb_i.psel <= 1'b1;
    apb_i.penable <= 1'b0;
    apb_i.pwrite <= wr;
    apb_i.paddr <= a;
    apb_i.pwdata <= d;
    @(posedge clk_sys);
    apb_i.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (apb_o.pready !== 1'b1 && n < 50);
    if (apb_o.pready !== 1'b1) give_up();
    q = apb_o.prdata;
    e = apb_o.pslverr;
    apb_i.psel <= 1'b0;
    apb_i.penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  // Reads a register and compares the bits selected by m.
  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] x);
    apb(1'b0, a, 32'h0);
    chk_val(q & {24'h0, m}, {24'h0, x});
  endtask

  // Sends two commands under ATN, then releases ATN.
  task automatic talk(input gpib_talker_pkg::cmd_e c1,
                      input gpib_talker_pkg::cmd_e c2);
    atn_set <= 1'b1;
    cyc(2);
    cmd_code <= c1;
    cmd_go <= 1'b1;
    @(posedge clk_sys);
    cmd_go <= 1'b0;
    cyc(2);
    cmd_code <= c2;
    cmd_go <= 1'b1;
    @(posedge clk_sys);
    cmd_go <= 1'b0;
    cyc(2);
    atn_set <= 1'b0;
    cyc(4);
  endtask

  task automatic wait_bytes(input logic [7:0] n);
    int k;
    k = 0;
    while (nbytes !== n && k < 200) begin
      @(posedge clk_sys);
      k++;
    end
    if (nbytes !== n) give_up();
  endtask

  // Reset state, unmapped access and the end-of-string request.
  task automatic t_end();
    rd(8'h00, 8'hff, 8'h00);
    apb(1'b0, 8'h1c, 32'h0);
    chk_pin(e, 1'b1);
    wr(8'h0c, 8'h20);
    cyc(2);
    chk_pin(bus_o.eoi_oe, 1'b0);
    rd(8'h0c, 8'h20, 8'h00);
    slow <= 1'b1;
    talk(gpib_talker_pkg::C_MTA, gpib_talker_pkg::C_MTA);
    chk_pin(bus_o.eoi_oe, 1'b1);
    chk_pin(bus_o.od_val, 1'b0);
    wr(8'h14, 8'ha5);
    wait_bytes(8'h01);
    cyc(3);
    chk_val({24'h0, last_byte}, 32'ha5);
    chk_pin(last_eoi, 1'b1);
    chk_pin(bus_o.eoi_oe, 1'b0);
    rd(8'h00, 8'hff, 8'h02);
    chk_pin(bus_o.irq_oe, 1'b0);
    slow <= 1'b0;
  endtask

  // ATN, readdressing, untalking and the command holdoff.
  task automatic t_atn();
    unt = '{gpib_talker_pkg::C_MLA, gpib_talker_pkg::C_OTA,
            gpib_talker_pkg::C_UNT};
    talk(gpib_talker_pkg::C_MTA, gpib_talker_pkg::C_MTA);
    rd(8'h00, 8'h02, 8'h02);
    atn_set <= 1'b1;
    cyc(3);
    rd(8'h00, 8'h02, 8'h00);
    rd(8'h08, 8'h08, 8'h00);
    for (int i = 0; i < 3; i++) begin
      talk(unt[i], unt[i]);
      rd(8'h00, 8'h02, 8'h00);
      talk(gpib_talker_pkg::C_MTA, gpib_talker_pkg::C_MTA);
    end
    wr(8'h0c, 8'h04);
    atn_set <= 1'b1;
    cmd_code <= gpib_talker_pkg::C_OTHER;
    cmd_go <= 1'b1;
    @(posedge clk_sys);
    cmd_go <= 1'b0;
    cyc(3);
    chk_pin(bus_o.cmd_hold, 1'b1);
    wr(8'h0c, 8'h10);
    cyc(1);
    chk_pin(bus_o.cmd_hold, 1'b0);
    rd(8'h0c, 8'h04, 8'h00);
    talk(gpib_talker_pkg::C_MTA, gpib_talker_pkg::C_MTA);
  endtask

  // Service request, a single poll, then a repeating poll.
  task automatic t_poll();
    wr(8'h00, 8'h04);
    wr(8'h10, 8'h41);
    cyc(1);
    chk_pin(bus_o.srq_oe, 1'b1);
    rfd_en <= 1'b0;
    talk(gpib_talker_pkg::C_SPE, gpib_talker_pkg::C_MTA);
    chk_pin(bus_o.srq_oe, 1'b0);
    chk_pin(bus_o.dio_oe, 1'b1);
    chk_val({24'h0, bus_o.dio}, 32'h41);
    rd(8'h04, 8'h04, 8'h04);
    rd(8'h10, 8'h40, 8'h00);
    chk_pin(bus_o.irq_oe, 1'b1);
    wr(8'h10, 8'h00);
    nb0 = nbytes;
    rfd_en <= 1'b1;
    wait_bytes(nb0 + 8'h01);
    chk_val({24'h0, last_byte}, 32'h41);
    cyc(20);
    chk_val({24'h0, nbytes}, {24'h0, nb0 + 8'h01});
    chk_pin(bus_o.dio_oe, 1'b0);
    rd(8'h00, 8'h16, 8'h14);
    chk_pin(bus_o.irq_oe, 1'b0);
    talk(gpib_talker_pkg::C_SPD, gpib_talker_pkg::C_OTHER);
    rd(8'h04, 8'h04, 8'h00);
    wr(8'h10, 8'h41);
    cyc(1);
    chk_pin(bus_o.srq_oe, 1'b0);
    wr(8'h10, 8'h01);
    wr(8'h10, 8'h41);
    cyc(1);
    chk_pin(bus_o.srq_oe, 1'b1);
    rfd_en <= 1'b0;
    wr(8'h14, 8'h3c);
    talk(gpib_talker_pkg::C_SPE, gpib_talker_pkg::C_MTA);
    nb0 = nbytes;
    rfd_en <= 1'b1;
    wait_bytes(nb0 + 8'h02);
    chk_val({24'h0, last_byte}, 32'h41);
    rfd_en <= 1'b0;
    talk(gpib_talker_pkg::C_SPD, gpib_talker_pkg::C_OTHER);
    rd(8'h00, 8'h16, 8'h10);
  endtask

  // A reset in mid-run drops a pending end request.
  task automatic t_rst();
    atn_set <= 1'b1;
    cyc(2);
    wr(8'h0c, 8'h20);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    rfd_en <= 1'b1;
    talk(gpib_talker_pkg::C_MTA, gpib_talker_pkg::C_MTA);
    chk_pin(bus_o.eoi_oe, 1'b0);
    chk_pin(bus_o.srq_oe, 1'b0);
  endtask

  // Main sequence.
  initial begin
    rst = 1'b1;
    apb_i = '0;
    atn_set = 1'b0;
    cmd_go = 1'b0;
    cmd_code = gpib_talker_pkg::C_OTHER;
    rfd_en = 1'b1;
    slow = 1'b0;
    fails = 0;
    checks = 0;
    cyc(8);
    rst <= 1'b0;
    cyc(1);
    t_end();
    t_atn();
    t_poll();
    t_rst();
    complete_run();
  end
endmodule
